/* dv/spims_peer.sv */
// Purpose: external serial slave facing the block in master role
// Assumes: select driven by the bench, mode and order set by the bench
// Notes:   released data line shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module spims_peer
(
    input  wire logic       i_sck,
    input  wire logic       i_mosi,
    input  wire logic       i_ss_n,
    input  wire logic [1:0] i_mode,
    input  wire logic       i_lsb,
    input  wire logic [7:0] i_tx,
    output var  logic       o_miso,
    output var  logic [7:0] o_rx,
    output var  logic [7:0] o_cnt
);
    logic [2:0] idx;
    initial
    begin
        o_miso = 1'b0;
        o_rx = 8'h00;
        o_cnt = 8'h00;
        idx = 3'h0;
    end
    always @(negedge i_ss_n)
    begin
        idx = 3'h0;
        o_miso = i_lsb ? i_tx[0] : i_tx[7];
    end
    always @(posedge i_ss_n)
        o_miso = ~o_miso;
    // sample edge is rising when polarity equals phase
    always @(i_sck)
        if (!i_ss_n)
        begin
            if (i_sck == (i_mode[1] == i_mode[0]))
            begin
                o_rx = i_lsb ? {i_mosi, o_rx[7:1]} : {o_rx[6:0], i_mosi};
                idx = idx + 3'h1;
                if (idx == 3'h0)
                    o_cnt = o_cnt + 8'h01;
            end
            else
                o_miso = i_lsb ? i_tx[idx] : i_tx[~idx];
        end
endmodule // spims_peer
`default_nettype wire

/* dv/spims_sva.sv */
// Purpose: port-level assertions for the serial master/slave block
// Assumes: one clock, reset active high
// Notes:   bound to every spims_core instance
`timescale 1ns/1ps
`default_nettype none
module spims_sva
(
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic [2:0] i_addr,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic       i_deep_sleep,
    input wire logic       i_ss_n,
    input wire logic       o_sck,
    input wire logic       o_sck_oe,
    input wire logic       o_mosi_oe,
    input wire logic       o_miso_oe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside read slot");
    a_unmapped_zero: assert property ($past(i_rd) && ($past(i_addr) > 3'h4) |-> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_master_oe_pair: assert property (o_sck_oe == o_mosi_oe)
        else $error("clock and data enables disagree");
    a_role_exclusive: assert property (!(o_miso_oe && o_mosi_oe))
        else $error("master and slave outputs both driven");
    a_slave_oe_select: assert property (o_miso_oe |-> !$past(i_ss_n))
        else $error("slave output driven while deselected");
    a_slave_sck_still: assert property (o_miso_oe && $past(o_miso_oe) |-> $stable(o_sck))
        else $error("serial clock moved in slave role");
    a_sleep_sck_still: assert property (i_deep_sleep && $past(i_deep_sleep)
        && $past(i_deep_sleep, 2) && $past(i_deep_sleep, 3) |-> $stable(o_sck))
        else $error("serial clock moved in deep sleep");
    a_idle_sck_still: assert property (!o_sck_oe && !$past(o_sck_oe) && !$past(o_sck_oe, 2)
        && !$past(i_wr) && !$past(i_wr, 2) && !$past(i_wr, 3) |-> $stable(o_sck))
        else $error("serial clock moved while not master");
endmodule // spims_sva

bind spims_core spims_sva spims_sva_inst
(
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_addr       (i_addr),
    .i_wr         (i_wr),
    .i_rd         (i_rd),
    .o_rdata      (o_rdata),
    .i_deep_sleep (i_deep_sleep),
    .i_ss_n       (i_ss_n),
    .o_sck        (o_sck),
    .o_sck_oe     (o_sck_oe),
    .o_mosi_oe    (o_mosi_oe),
    .o_miso_oe    (o_miso_oe)
);
`default_nettype wire

/* dv/test_spims_core.sv */
// Purpose: self-checking bench for the serial master/slave block
// Assumes: 40 MHz clock, strobe register port
// Notes:   random master transfers over every mode and divider
`timescale 1ns/1ps
`default_nettype none
module test_spims_core;
    logic       i_clk, i_rst, i_wr, i_rd, i_deep_sleep, i_sck, i_mosi, i_ss_n;
    logic [2:0] i_addr;
    logic [7:0] i_wdata, o_rdata, p_tx, p_rx, p_cnt, gap, v;
    logic       o_sck, o_sck_oe, o_mosi, o_mosi_oe, o_miso, o_miso_oe, o_irq, miso;
    logic       peer_ss_n, p_lsb, last_sck;
    logic [1:0] p_mode;
    logic [31:0] r;
    int         miscompares, n_checks, cyc, tog, lastt, k;

    spims_core spims_core_inst
    (
        .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_deep_sleep(i_deep_sleep),
        .i_sck(i_sck), .o_sck(o_sck), .o_sck_oe(o_sck_oe), .i_mosi(i_mosi),
        .o_mosi(o_mosi), .o_mosi_oe(o_mosi_oe), .i_miso(miso), .o_miso(o_miso),
        .o_miso_oe(o_miso_oe), .i_ss_n(i_ss_n), .o_irq(o_irq)
    );
    spims_peer spims_peer_inst
    (
        .i_sck(o_sck), .i_mosi(o_mosi), .i_ss_n(peer_ss_n), .i_mode(p_mode),
        .i_lsb(p_lsb), .i_tx(p_tx), .o_miso(miso), .o_rx(p_rx), .o_cnt(p_cnt)
    );

    initial
    begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    task close_out;
        begin
            $display("checks %0d mismatches %0d", n_checks, miscompares);
            if (miscompares == 0 && n_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask

    // cycles, clock toggles, half period, hang guard
    always @(negedge i_clk)
    begin
        cyc = cyc + 1;
        if (o_sck !== last_sck)
        begin
            tog = tog + 1;
            if (tog == 2)
                gap = 8'(cyc - lastt);
            lastt = cyc;
        end
        last_sck = o_sck;
        if (cyc == 80000)
        begin
            miscompares = miscompares + 1;
            close_out;
        end
    end

    task chk(input string nm, input [7:0] e, input [7:0] g);
        begin
            n_checks = n_checks + 1;
            if (g !== e)
            begin
                miscompares = miscompares + 1;
                $display("MISMATCH %s expected %h seen %h", nm, e, g);
            end
        end
    endtask

    task wr(input [2:0] a, input [7:0] d);
        begin
            @(posedge i_clk);
            i_addr <= a;
            i_wdata <= d;
            i_wr <= 1'b1;
            @(posedge i_clk);
            i_wr <= 1'b0;
        end
    endtask

    task rd(input [2:0] a, output [7:0] d);
        begin
            @(posedge i_clk);
            i_addr <= a;
            i_rd <= 1'b1;
            @(posedge i_clk);
            i_rd <= 1'b0;
            #1 d = o_rdata;
        end
    endtask

    task wait_flag(input [2:0] b, output [7:0] f);
        int n;
        begin
            f = 8'h00;
            for (n = 0; n < 1000 && f[b] !== 1'b1; n = n + 1)
                rd(3'h3, f);
            chk("flag_wait", 8'h01, {7'h00, f[b]});
        end
    endtask

    function [7:0] half_of(input [1:0] dv, input db);
        logic [7:0] h;
        begin
            case (dv)
                2'h0: h = 8'h02;
                2'h1: h = 8'h08;
                2'h2: h = 8'h20;
                default: h = 8'h40;
            endcase
            half_of = h >> db;
        end
    endfunction

    task mx(input [1:0] md, input [1:0] dv, input db, input lb, input [7:0] d,
            input [7:0] pd, input cl);
        logic [7:0] f;
        begin
            p_tx = pd;
            p_mode = md;
            p_lsb = lb;
            wr(3'h1, {6'h00, md});
            wr(3'h0, {1'b0, lb, 1'b1, db, 1'b0, dv, 1'b1});
            peer_ss_n <= 1'b0;
            repeat (4) @(posedge i_clk);
            tog = 0;
            wr(3'h4, d);
            if (cl)
                wr(3'h4, ~d);
            wait_flag(3'h7, f);
            chk("flags", {1'b1, cl, 6'h00}, f);
            chk("peer_rx", d, p_rx);
            chk("toggles", 8'h10, tog[7:0]);
            chk("half", half_of(dv, db), gap);
            chk("idle", {7'h00, md[1]}, {7'h00, o_sck});
            chk("irq_on", 8'h01, {7'h00, o_irq});
            rd(3'h4, f);
            chk("rx_byte", pd, f);
            repeat (2) @(negedge i_clk);
            chk("irq_off", 8'h00, {7'h00, o_irq});
            peer_ss_n <= 1'b1;
        end
    endtask

    // bench as master on the slave pins, mode 0, msb first
    task sb(input [7:0] d, input int n);
        int j;
        begin
            i_ss_n <= 1'b0;
            for (j = 0; j < n; j = j + 1)
            begin
                i_mosi <= d[7 - j];
                repeat (4) @(posedge i_clk);
                i_sck <= 1'b1;
                repeat (4) @(posedge i_clk);
                i_sck <= 1'b0;
            end
            repeat (4) @(posedge i_clk);
            i_ss_n <= 1'b1;
            i_mosi <= ~i_mosi;
            @(posedge i_clk);
        end
    endtask

    initial
    begin
        {i_rst, i_ss_n, peer_ss_n} = 3'h7;
        {i_wr, i_rd, i_deep_sleep, i_sck, i_mosi, p_lsb, last_sck} = 7'h00;
        {i_addr, i_wdata, p_tx, p_mode, gap} = 29'h0;
        r = $urandom(85);
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        wr(3'h5, 8'hff);
        for (k = 0; k < 8; k = k + 1)
        begin
            rd(k[2:0], v);
            chk("reset_val", 8'h00, v);
        end
        wr(3'h0, 8'hff);
        rd(3'h0, v);
        chk("ctrl_a_bits", 8'h77, v);
        wr(3'h0, 8'h00);
        wr(3'h2, 8'hff);
        rd(3'h2, v);
        chk("irq_en_unbuf", 8'h01, v);
        for (k = 0; k < 16; k = k + 1)
        begin
            r = $urandom;
            mx(k[1:0], k[3:2], r[0], r[1], r[15:8], r[23:16], k == 5);
        end
        // abort by deep sleep in the first half period of a byte, before any clock edge
        wr(3'h0, 8'h27);
        wr(3'h4, r[31:24]);
        repeat (40) @(posedge i_clk);
        i_deep_sleep <= 1'b1;
        repeat (8) @(posedge i_clk);
        k = tog;
        repeat (300) @(posedge i_clk);
        chk("sleep_toggles", k[7:0], tog[7:0]);
        rd(3'h3, v);
        chk("sleep_flags", 8'h00, v);
        i_deep_sleep <= 1'b0;
        wr(3'h0, 8'h26);
        tog = 0;
        wr(3'h4, r[7:0]);
        repeat (100) @(posedge i_clk);
        chk("off_toggles", 8'h00, tog[7:0]);
        // select pin against a master
        wr(3'h0, 8'h21);
        wr(3'h1, 8'h04);
        i_ss_n <= 1'b0;
        rd(3'h0, v);
        chk("override_master", 8'h21, v);
        wr(3'h1, 8'h00);
        repeat (2) @(posedge i_clk);
        rd(3'h0, v);
        chk("dropped_master", 8'h01, v);
        rd(3'h3, v);
        chk("drop_flags", 8'h80, v);
        i_ss_n <= 1'b1;
        rd(3'h4, v);
        // slave role, partial byte then whole byte
        wr(3'h0, 8'h07);
        sb(r[15:8], 3);
        sb(r[23:16], 8);
        rd(3'h3, v);
        chk("slave_flags", 8'h80, v);
        rd(3'h4, v);
        chk("slave_rx", r[23:16], v);
        // buffered: direct write, then dummy byte
        wr(3'h0, 8'h21);
        wr(3'h1, 8'hc0);
        wr(3'h2, 8'hf0);
        rd(3'h2, v);
        chk("irq_en_buf", 8'hf0, v);
        wr(3'h3, 8'h50);
        {p_tx, p_mode, p_lsb} = {r[7:0], 3'h0};
        peer_ss_n <= 1'b0;
        k = p_cnt;
        wr(3'h4, r[15:8]);
        wr(3'h4, r[23:16]);
        rd(3'h3, v);
        chk("tx_empty_low", 8'h00, v & 8'h20);
        wait_flag(3'h6, v);
        chk("buf_flags", 8'he0, v & 8'he0);
        chk("buf_bytes", 8'h02, p_cnt - k[7:0]);
        chk("peer_last", r[23:16], p_rx);
        chk("buf_irq", 8'h01, {7'h00, o_irq});
        rd(3'h4, v);
        chk("buf_rx", r[7:0], v);
        wr(3'h1, 8'h80);
        wr(3'h4, r[31:24]);
        wait_flag(3'h0, v);
        chk("ovf_flags", 8'he1, v & 8'he1);
        chk("dummy_last", r[31:24], p_rx);
        peer_ss_n <= 1'b1;
        close_out;
    end
endmodule // test_spims_core
`default_nettype wire

/* rtl/spims_consts.vh */
// Purpose: shared constants of the byte-wide serial master/slave block
// Assumes: 3-bit register address, 8-bit registers
// Notes:   all four sources share one interrupt vector, offset 8'h00
`ifndef SPIMS_CONSTS_VH
`define SPIMS_CONSTS_VH

// register offsets
`define SPIMS_OFF_CONTROL_A   3'h0
`define SPIMS_OFF_CONTROL_B   3'h1
`define SPIMS_OFF_IRQ_EN      3'h2
`define SPIMS_OFF_IRQ_FLAGS   3'h3
`define SPIMS_OFF_SHIFT_DATA  3'h4

// reset value of every register
`define SPIMS_RST_REG         8'h00

// writable bits
`define SPIMS_MASK_CONTROL_A  8'h77
`define SPIMS_MASK_CONTROL_B  8'hc7
`define SPIMS_MASK_IRQ_EN     8'hf1

// control_a fields
`define SPIMS_A_BIT_ORDER     6
`define SPIMS_A_MASTER        5
`define SPIMS_A_RATE_DOUBLE   4
`define SPIMS_A_DIV_HI        2
`define SPIMS_A_DIV_LO        1
`define SPIMS_A_ENABLE        0

// control_b fields
`define SPIMS_B_BUFFERED      7
`define SPIMS_B_BUF_WAIT      6
`define SPIMS_B_SEL_OVERRIDE  2
`define SPIMS_B_POLARITY      1
`define SPIMS_B_PHASE         0

// interrupt enable and flag positions
`define SPIMS_I_RX_DONE       7
`define SPIMS_I_TX_DONE       6
`define SPIMS_I_TX_EMPTY      5
`define SPIMS_I_SEL_TRIG      4
`define SPIMS_I_GENERAL       0
`define SPIMS_F_OVERRUN       0

// half serial clock periods in peripheral clocks, undoubled
`define SPIMS_HALF_DIVIDE_BY_FOUR       7'h02
`define SPIMS_HALF_DIV16      7'h08
`define SPIMS_HALF_DIV64      7'h20
`define SPIMS_HALF_DIVIDE_BY_128     7'h40

// serial clock edges per byte, last index
`define SPIMS_LAST_EDGE       4'hf

`endif

/* rtl/spims_core.v */
// Purpose: byte-wide serial interface, master or slave, optional buffering
// Assumes: pins synchronous to i_clk; select pin always an input
// Notes:   registers on a plain strobe port, read data one cycle later
`timescale 1ns/1ps
`default_nettype none
`include "spims_consts.vh"

// How it works
// - every interrupt condition sets its own flag bit
// - request raised while flag and enable both set, held until flag clears
// - select trigger, tx empty, tx done, rx done share one request line
// - idle sleep keeps running; deeper sleep aborts the current transfer
// - bit order 0 sends msb first, 1 sends lsb first
// - role bit 0 is slave, 1 is master
// - master with select low and no override drops to slave, sets byte-done
// - override bit set makes the select pin harmless to a master
// - divider field picks clock divided by 4, 16, 64 or 128
// - divider field ignored in slave role
// - rate double bit doubles master serial clock rate
// - enable bit switches interface on; no transfers while off
// - buffered mode gives two rx stages, one tx stage, split flags
// - buffer wait 0: first byte sent is a dummy, data waits one transfer
// - buffer wait 1: first write while idle and deselected loads shifter
// - mode phase bit chooses sample on leading or trailing edge
// - mode polarity bit chooses idle level and leading edge direction
// - buffered enables gate their own flags; unbuffered they read zero
// - unbuffered, general enable gates the byte-done flag
// - slave deselect resets the bit counter and drops the partial byte
// - unbuffered data write during a byte is dropped, sets write clash
// - buffered, data write into the tx stage clears tx empty; reload into shifter sets it
// - buffered, byte completing with both rx stages full sets overrun
module spims_core
(
    input  wire       i_clk,
    input  wire       i_rst,
    input  wire [2:0] i_addr,
    input  wire [7:0] i_wdata,
    input  wire       i_wr,
    input  wire       i_rd,
    output reg  [7:0] o_rdata,
    input  wire       i_deep_sleep,
    input  wire       i_sck,
    output reg        o_sck,
    output reg        o_sck_oe,
    input  wire       i_mosi,
    output wire       o_mosi,
    output reg        o_mosi_oe,
    input  wire       i_miso,
    output wire       o_miso,
    output reg        o_miso_oe,
    input  wire       i_ss_n,
    output reg        o_irq
);

    reg  [7:0] control_a;
    reg  [7:0] control_b;
    reg  [7:0] interrupt_enables;
    reg  [7:0] shifter;
    reg        out_bit;
    reg        active;
    reg  [3:0] edge_cnt;
    reg  [6:0] div_cnt;
    reg        done_d;
    reg        sck_prev;
    reg  [7:0] tx_buf;
    reg        tx_full;
    reg  [7:0] rx_first;
    reg        rx_first_v;
    reg  [7:0] rx_second;
    reg        rx_second_v;
    reg  [7:0] rx_plain;
    reg        byte_done_flag;
    reg        write_clash_flag;
    reg        tx_done_flag;
    reg        select_trigger_flag;
    reg        rx_overrun_flag;
    reg        done_armed;
    reg        clash_armed;
    reg  [7:0] next_rx_first;
    reg        next_rx_first_v;
    reg  [7:0] next_rx_second;
    reg        next_rx_second_v;
    reg        next_overrun;
    reg  [7:0] next_rdata;

    wire       enable_on        = control_a[`SPIMS_A_ENABLE];
    wire       master_on        = control_a[`SPIMS_A_MASTER];
    wire       bit_order_select = control_a[`SPIMS_A_BIT_ORDER];
    wire       rate_double      = control_a[`SPIMS_A_RATE_DOUBLE];
    wire [1:0] clock_divider    = control_a[`SPIMS_A_DIV_HI:`SPIMS_A_DIV_LO];
    wire       buffered_mode_on = control_b[`SPIMS_B_BUFFERED];
    wire       buf_wait_recv    = control_b[`SPIMS_B_BUF_WAIT];
    wire       select_override  = control_b[`SPIMS_B_SEL_OVERRIDE];
    wire       clk_polarity     = control_b[`SPIMS_B_POLARITY];
    wire       clk_phase        = control_b[`SPIMS_B_PHASE];

    function [6:0] half_period;
        input [1:0] div;
        input       dbl;
        reg   [6:0] base;
        begin
            case (div)
                2'h0:    base = `SPIMS_HALF_DIVIDE_BY_FOUR;
                2'h1:    base = `SPIMS_HALF_DIV16;
                2'h2:    base = `SPIMS_HALF_DIV64;
                default: base = `SPIMS_HALF_DIVIDE_BY_128;
            endcase
            half_period = dbl ? {1'b0, base[6:1]} : base;
        end
    endfunction

    // bit that goes out first for a given order
    function first_bit;
        input [7:0] v;
        input       lsb_first;
        begin
            first_bit = lsb_first ? v[0] : v[7];
        end
    endfunction

    wire [6:0] half      = half_period(clock_divider, rate_double);
    wire       tick      = active && (div_cnt == (half - 7'h01));
    wire       selected  = enable_on && !master_on && !i_ss_n;
    wire       slv_edge  = selected && (sck_prev != i_sck);
    wire       edge_now  = master_on ? tick : slv_edge;
    wire       lead      = master_on ? !edge_cnt[0] : (sck_prev == clk_polarity);
    wire       samp      = edge_now && (lead != clk_phase);
    wire       setup     = edge_now && (lead == clk_phase);
    wire       in_bit    = master_on ? i_miso : i_mosi;
    wire [7:0] shifted   = bit_order_select ? {in_bit, shifter[7:1]}
                                            : {shifter[6:0], in_bit};
    wire       ss_trip   = enable_on && master_on && !select_override && !i_ss_n;
    wire       abort     = !enable_on || i_deep_sleep || ss_trip;
    wire       busy      = active || done_d || (edge_cnt != 4'h0);
    wire       wr_data   = i_wr && (i_addr == `SPIMS_OFF_SHIFT_DATA);
    wire       rd_data   = i_rd && (i_addr == `SPIMS_OFF_SHIFT_DATA);
    wire       wr_flags  = i_wr && (i_addr == `SPIMS_OFF_IRQ_FLAGS);
    wire       rd_flags  = i_rd && (i_addr == `SPIMS_OFF_IRQ_FLAGS);
    wire       direct_ok = enable_on && i_ss_n && !busy && !tx_full;
    wire       tx_empty  = buffered_mode_on && !tx_full;
    wire [7:0] en_view   = {buffered_mode_on ? interrupt_enables[7:4] : 4'h0,
                            3'h0, interrupt_enables[`SPIMS_I_GENERAL]};
    wire [7:0] flag_view = buffered_mode_on
                         ? {rx_second_v, tx_done_flag, tx_empty, select_trigger_flag,
                            3'h0, rx_overrun_flag}
                         : {byte_done_flag, write_clash_flag, 6'h00};
    wire       irq_buf   = |({rx_second_v, tx_done_flag, tx_empty, select_trigger_flag}
                            & interrupt_enables[7:4]);
    wire       irq_plain = interrupt_enables[`SPIMS_I_GENERAL] && byte_done_flag;

    assign o_mosi = out_bit;
    assign o_miso = out_bit;

    // two-stage receive buffer: read pops, then a finished byte pushes
    always @*
    begin
        next_rx_first    = rx_first;
        next_rx_first_v  = rx_first_v;
        next_rx_second   = rx_second;
        next_rx_second_v = rx_second_v;
        next_overrun     = 1'b0;
        if (rd_data && buffered_mode_on)
        begin
            next_rx_second   = rx_first;
            next_rx_second_v = rx_first_v;
            next_rx_first_v  = 1'b0;
        end
        if (done_d && buffered_mode_on)
        begin
            if (!next_rx_second_v)
            begin
                next_rx_second   = shifter;
                next_rx_second_v = 1'b1;
            end
            else if (!next_rx_first_v)
            begin
                next_rx_first   = shifter;
                next_rx_first_v = 1'b1;
            end
            else
            begin
                next_overrun = 1'b1;
            end
        end
    end

    always @*
    begin
        case (i_addr)
            `SPIMS_OFF_CONTROL_A:  next_rdata = control_a;
            `SPIMS_OFF_CONTROL_B:  next_rdata = control_b;
            `SPIMS_OFF_IRQ_EN:     next_rdata = en_view;
            `SPIMS_OFF_IRQ_FLAGS:  next_rdata = flag_view;
            `SPIMS_OFF_SHIFT_DATA: next_rdata = buffered_mode_on ? rx_second : rx_plain;
            default:               next_rdata = 8'h00;
        endcase
    end

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            control_a           <= `SPIMS_RST_REG;
            control_b           <= `SPIMS_RST_REG;
            interrupt_enables   <= `SPIMS_RST_REG;
            shifter             <= 8'h00;
            out_bit             <= 1'b0;
            active              <= 1'b0;
            edge_cnt            <= 4'h0;
            div_cnt             <= 7'h00;
            done_d              <= 1'b0;
            sck_prev            <= 1'b0;
            tx_buf              <= 8'h00;
            tx_full             <= 1'b0;
            rx_first            <= 8'h00;
            rx_first_v          <= 1'b0;
            rx_second           <= 8'h00;
            rx_second_v         <= 1'b0;
            rx_plain            <= 8'h00;
            byte_done_flag      <= 1'b0;
            write_clash_flag    <= 1'b0;
            tx_done_flag        <= 1'b0;
            select_trigger_flag <= 1'b0;
            rx_overrun_flag     <= 1'b0;
            done_armed          <= 1'b0;
            clash_armed         <= 1'b0;
            o_rdata             <= 8'h00;
            o_sck               <= 1'b0;
            o_sck_oe            <= 1'b0;
            o_mosi_oe           <= 1'b0;
            o_miso_oe           <= 1'b0;
            o_irq               <= 1'b0;
        end
        else
        begin
            sck_prev  <= i_sck;
            o_sck_oe  <= enable_on && master_on;
            o_mosi_oe <= enable_on && master_on;
            o_miso_oe <= selected;
            o_rdata   <= i_rd ? next_rdata : 8'h00;
            o_irq     <= buffered_mode_on ? irq_buf : irq_plain;
            done_d    <= 1'b0;
            rx_first    <= next_rx_first;
            rx_first_v  <= next_rx_first_v;
            rx_second   <= next_rx_second;
            rx_second_v <= next_rx_second_v;

            // flag clears first so that any set below wins
            if (rd_flags && byte_done_flag)
                done_armed <= 1'b1;
            if (rd_flags && write_clash_flag)
                clash_armed <= 1'b1;
            if ((rd_data || wr_data) && done_armed)
            begin
                byte_done_flag <= 1'b0;
                done_armed     <= 1'b0;
            end
            if ((rd_data || wr_data) && clash_armed)
            begin
                write_clash_flag <= 1'b0;
                clash_armed      <= 1'b0;
            end
            if (wr_flags && i_wdata[`SPIMS_I_TX_DONE])
                tx_done_flag <= 1'b0;
            if (wr_flags && i_wdata[`SPIMS_I_SEL_TRIG])
                select_trigger_flag <= 1'b0;
            if (rd_data)
                rx_overrun_flag <= 1'b0;
            if (next_overrun)
                rx_overrun_flag <= 1'b1;

            // master clock divider
            if (active)
                div_cnt <= tick ? 7'h00 : div_cnt + 7'h01;
            else
                o_sck <= clk_polarity;

            // one serial clock edge
            if (edge_now)
            begin
                if (samp)
                    shifter <= shifted;
                if (setup)
                    out_bit <= first_bit(shifter, bit_order_select);
                if (master_on)
                    o_sck <= !o_sck;
                if (edge_cnt == `SPIMS_LAST_EDGE)
                begin
                    done_d   <= 1'b1;
                    active   <= 1'b0;
                    edge_cnt <= 4'h0;
                end
                else
                begin
                    edge_cnt <= edge_cnt + 4'h1;
                end
            end
            else if (!active && edge_cnt == 4'h0)
            begin
                out_bit <= first_bit(shifter, bit_order_select);
            end

            // data register write
            if (wr_data)
            begin
                if (buffered_mode_on)
                begin
                    if (buf_wait_recv && direct_ok)
                    begin
                        shifter <= i_wdata;
                        out_bit <= first_bit(i_wdata, bit_order_select);
                        if (master_on)
                        begin
                            active  <= 1'b1;
                            div_cnt <= 7'h00;
                        end
                    end
                    else if (!tx_full)
                    begin
                        tx_buf  <= i_wdata;
                        tx_full <= 1'b1;
                        if (!buf_wait_recv && master_on && enable_on && !busy)
                        begin
                            active  <= 1'b1;
                            div_cnt <= 7'h00;
                        end
                    end
                end
                else if (busy)
                begin
                    write_clash_flag <= 1'b1;
                end
                else
                begin
                    shifter <= i_wdata;
                    out_bit <= first_bit(i_wdata, bit_order_select);
                    if (master_on && enable_on)
                    begin
                        active  <= 1'b1;
                        div_cnt <= 7'h00;
                    end
                end
            end

            // byte finished one cycle ago, shifter holds the received byte
            if (done_d)
            begin
                if (buffered_mode_on)
                begin
                    if (tx_full)
                    begin
                        shifter <= tx_buf;
                        out_bit <= first_bit(tx_buf, bit_order_select);
                        tx_full <= 1'b0;
                        if (master_on && enable_on)
                        begin
                            active  <= 1'b1;
                            div_cnt <= 7'h00;
                        end
                    end
                    else
                    begin
                        tx_done_flag <= 1'b1;
                    end
                end
                else
                begin
                    rx_plain       <= shifter;
                    byte_done_flag <= 1'b1;
                end
            end

            // slave deselect drops the partial byte
            if (!master_on && i_ss_n)
                edge_cnt <= 4'h0;

            if (abort)
            begin
                active   <= 1'b0;
                edge_cnt <= 4'h0;
                done_d   <= 1'b0;
                o_sck    <= clk_polarity;
            end

            // register writes
            if (i_wr && i_addr == `SPIMS_OFF_CONTROL_A)
                control_a <= i_wdata & `SPIMS_MASK_CONTROL_A;
            if (i_wr && i_addr == `SPIMS_OFF_CONTROL_B)
                control_b <= i_wdata & `SPIMS_MASK_CONTROL_B;
            if (i_wr && i_addr == `SPIMS_OFF_IRQ_EN)
                interrupt_enables <= i_wdata & `SPIMS_MASK_IRQ_EN;

            if (ss_trip)
            begin
                control_a[`SPIMS_A_MASTER] <= 1'b0;
                byte_done_flag             <= 1'b1;
                if (buffered_mode_on)
                    select_trigger_flag <= 1'b1;
            end
        end
    end

endmodule // spims_core

`default_nettype wire
